/* cfps_pkg.sv */
// cfps_pkg: constants and carrier types for the charger fault protection sequencer
// assumes a 50 MHz system clock; all analog decisions arrive as synchronous comparator flags
package cfps_pkg;

  // ==========================================================================
  // clock and timing
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_NS   = 20;
  localparam int unsigned OVP_DISABLE_US  = 30000;
  localparam int unsigned LOW_RESET_US    = 1000;
  localparam int unsigned LOW_RESTART_US  = 4500;
  localparam int unsigned OVP_DISABLE_CYC = (OVP_DISABLE_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned LOW_RESET_CYC   = (LOW_RESET_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned LOW_RESTART_CYC = (LOW_RESTART_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned BLANK_CYC       = 8;
  localparam int unsigned TMR_W           = 21;

  // ==========================================================================
  // short-circuit counting
  // ==========================================================================
  localparam int unsigned    SHORT_CNT_W     = 3;
  localparam logic [2:0]     SHORT_LIMIT     = 3'h7;

  // ==========================================================================
  // option word field positions
  // ==========================================================================
  localparam int unsigned OPT_LS_THR_BIT   = 7;
  localparam int unsigned OPT_HS_EN_BIT    = 8;
  localparam int unsigned OPT_FADJ_EN_BIT  = 9;
  localparam int unsigned OPT_FADJ_UP_BIT  = 10;
  localparam logic [15:0] OPT_RESET        = 16'h0000;

  // frequency trim code: 00 nominal, 01 lowered, 10 raised
  typedef enum logic [1:0] {
    CFPS_FREQ_NOM  = 2'h0,
    CFPS_FREQ_LOW  = 2'h1,
    CFPS_FREQ_HIGH = 2'h2
  } cfps_freq_t;

  typedef struct packed {
    logic hs_gate_en;
    logic ls_gate_en;
    logic ls_refresh_only;
    logic current_cap;
    logic discharge_sink;
    logic soft_start;
    logic charger_en;
  } cfps_drive_t;

  typedef struct packed {
    logic ovp;
    logic low;
    logic thermal;
    logic latched;
  } cfps_status_t;

endpackage : cfps_pkg

/* cfps_short_cnt.sv */
// cfps_short_cnt: one blanked short-circuit event counter
// assumes the comparator flag is synchronous and switch_on_i marks each switch turn-on
`timescale 1ns/1ps
module cfps_short_cnt
(
  // clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rst_n_i,
  // events
  input  wire logic                       switch_on_i,
  input  wire logic                       cmp_i,
  input  wire logic                       count_en_i,
  // result
  output logic [cfps_pkg::SHORT_CNT_W-1:0] count_o,
  output logic                             limit_o
);

  logic [3:0] blank_ff;
  logic       seen_ff;

  // blanking restarts at every turn-on; compare only after it expires
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      blank_ff <= 4'h0;
    else if (switch_on_i)
      blank_ff <= 4'(cfps_pkg::BLANK_CYC);
    else if (blank_ff != 4'h0)
      blank_ff <= blank_ff - 4'h1;
  end

  // one count per switching cycle at most
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      seen_ff <= 1'b0;
    else if (switch_on_i)
      seen_ff <= 1'b0;
    else if (cmp_i && blank_ff == 4'h0)
      seen_ff <= 1'b1;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      count_o <= '0;
    else if (count_en_i && cmp_i && blank_ff == 4'h0 && !seen_ff && !limit_o)
      count_o <= count_o + 3'h1;
  end

  assign limit_o = (count_o == cfps_pkg::SHORT_LIMIT);

  a_blank_ignore : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (blank_ff != 4'h0) |=> $stable(count_o))
    else $error("short count moved during blanking");

endmodule // cfps_short_cnt

/* cfps_sequencer.sv */
// cfps_sequencer: protection and fault sequencing for the charger buck stage
// assumes synchronous comparator flags from the analog front end and an option word held by the host interface
//
// Contract
// - gates off above 104% charge target
// - overvoltage over 30ms disables charger
// - 4mA sink only during overvoltage
// - zero voltage target suppresses overvoltage
// - battery low limits current, resets after 1ms
// - restart via soft-start 4-5ms after reset
// - battery low: 0.5A cap, low side refresh
// - thermal off above 155C, resume below 135C
// - thermal shutdown lowers regulator limit 16mA
// - bit 9 enables 18% frequency offset
// - bit 10 picks lower or higher frequency
// - short comparators sampled after blanking only; LS_CYCLE_LIMIT_O passes LS_SHORT_CMP_I unblanked during boost
// - seven events latch off, swap path switches
// - latch cleared only by lockout or detect
// - bit 7 picks 135mV or 230mV
// - bit 8 enables 750mV high-side detection
// - boost: low-side limit only, no counting
// - early peak shutoff may skip counting
// - soft-start may take longer to detect
// - peak overcurrent blanks high side per cycle
`timescale 1ns/1ps
module cfps_sequencer
(
  // clock and reset
  input  wire logic                   CLK_SYS_I,
  input  wire logic                   RST_N_I,
  // supply and adapter
  input  wire logic                   UNDERVOLTAGE_LOCKOUT_I,
  input  wire logic                   ADAPTER_DETECT_LOW_I,
  input  wire logic                   CHARGE_ENABLE_OK_I,
  // host option word and target
  input  wire logic [15:0]            CHARGER_OPTION_WORD_I,
  input  wire logic                   CHARGE_VOLTAGE_TARGET_ZERO_I,
  // comparator flags
  input  wire logic                   BATTERY_OVER_104_I,
  input  wire logic                   BATTERY_LOW_I,
  input  wire logic                   THERMAL_HOT_155_I,
  input  wire logic                   THERMAL_COOL_135_I,
  input  wire logic                   CHARGE_PEAK_OVERCURRENT_I,
  input  wire logic                   LS_SHORT_CMP_I,
  input  wire logic                   HS_SHORT_CMP_I,
  input  wire logic                   BOOST_ACTIVE_I,
  // converter timing
  input  wire logic                   CYCLE_START_I,
  input  wire logic                   HS_TURN_ON_I,
  input  wire logic                   LS_TURN_ON_I,
  // drive outputs
  output cfps_pkg::cfps_drive_t       DRIVE_O,
  output logic                        ADAPTER_PATH_SWITCH_ON_O,
  output logic                        REVERSE_BLOCK_SWITCH_ON_O,
  output logic                        BATTERY_PATH_SWITCH_ON_O,
  output logic                        GATE_DRIVE_REGULATOR_LIMIT_LOW_O,
  output cfps_pkg::cfps_freq_t        FREQ_TRIM_O,
  output logic                        LS_SHORT_THR_HIGH_O,
  output logic                        HS_SHORT_DETECT_EN_O,
  output logic                        LS_CYCLE_LIMIT_O,
  // status
  output cfps_pkg::cfps_status_t      STATUS_O
);

  typedef enum logic [1:0] {CFPS_LOW_IDLE, CFPS_LOW_LIMIT, CFPS_LOW_WAIT} cfps_low_t;

  // ==========================================================================
  // battery overvoltage
  // ==========================================================================
  logic                       ovp_act;
  logic [cfps_pkg::TMR_W-1:0] ovp_tmr_ff;
  logic                       ovp_disable_ff;

  assign ovp_act = BATTERY_OVER_104_I && !CHARGE_VOLTAGE_TARGET_ZERO_I;

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      ovp_tmr_ff <= '0;
    else if (!ovp_act)
      ovp_tmr_ff <= '0;
    else if (ovp_tmr_ff != cfps_pkg::TMR_W'(cfps_pkg::OVP_DISABLE_CYC))
      ovp_tmr_ff <= ovp_tmr_ff + 1'b1;
  end

  // disable holds until lockout or adapter removal restarts the device
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      ovp_disable_ff <= 1'b0;
    else if (UNDERVOLTAGE_LOCKOUT_I || ADAPTER_DETECT_LOW_I)
      ovp_disable_ff <= 1'b0;
    else if (ovp_act && ovp_tmr_ff == cfps_pkg::TMR_W'(cfps_pkg::OVP_DISABLE_CYC))
      ovp_disable_ff <= 1'b1;
  end

  // ==========================================================================
  // battery low sequence
  // ==========================================================================
  cfps_low_t                  low_st_ff;
  logic [cfps_pkg::TMR_W-1:0] low_tmr_ff;
  logic                       low_reset_pulse;

  assign low_reset_pulse = (low_st_ff == CFPS_LOW_LIMIT) && BATTERY_LOW_I &&
                           (low_tmr_ff == cfps_pkg::TMR_W'(cfps_pkg::LOW_RESET_CYC - 1));

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      low_st_ff  <= CFPS_LOW_IDLE;
      low_tmr_ff <= '0;
    end
    else
    begin
      case (low_st_ff)
        CFPS_LOW_IDLE:
        begin
          low_tmr_ff <= '0;
          if (BATTERY_LOW_I)
            low_st_ff <= CFPS_LOW_LIMIT;
        end
        CFPS_LOW_LIMIT:
        begin
          if (!BATTERY_LOW_I)
          begin
            low_st_ff  <= CFPS_LOW_IDLE;
            low_tmr_ff <= '0;
          end
          else if (low_reset_pulse)
          begin
            low_st_ff  <= CFPS_LOW_WAIT;
            low_tmr_ff <= '0;
          end
          else
            low_tmr_ff <= low_tmr_ff + 1'b1;
        end
        CFPS_LOW_WAIT:
        begin
          if (low_tmr_ff == cfps_pkg::TMR_W'(cfps_pkg::LOW_RESTART_CYC - 1))
          begin
            low_tmr_ff <= '0;
            if (CHARGE_ENABLE_OK_I)
              low_st_ff <= CFPS_LOW_IDLE;
          end
          else
            low_tmr_ff <= low_tmr_ff + 1'b1;
        end
        default:
          low_st_ff <= CFPS_LOW_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // thermal shutdown with hysteresis
  // ==========================================================================
  logic thermal_ff;

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      thermal_ff <= 1'b0;
    else if (THERMAL_HOT_155_I)
      thermal_ff <= 1'b1;
    else if (THERMAL_COOL_135_I)
      thermal_ff <= 1'b0;
  end

  // ==========================================================================
  // short-circuit counting and latch-off
  // ==========================================================================
  logic ls_limit;
  logic hs_limit;
  logic latch_ff;
  logic count_en;

  // boost only limits cycle by cycle; a peak shutoff inside blanking simply never counts
  assign count_en = !BOOST_ACTIVE_I;

  cfps_short_cnt u_ls_cnt
  (
    .clk_i       (CLK_SYS_I),
    .rst_n_i     (RST_N_I && !(UNDERVOLTAGE_LOCKOUT_I || ADAPTER_DETECT_LOW_I)),
    .switch_on_i (LS_TURN_ON_I),
    .cmp_i       (LS_SHORT_CMP_I),
    .count_en_i  (count_en),
    .count_o     (),
    .limit_o     (ls_limit)
  );

  cfps_short_cnt u_hs_cnt
  (
    .clk_i       (CLK_SYS_I),
    .rst_n_i     (RST_N_I && !(UNDERVOLTAGE_LOCKOUT_I || ADAPTER_DETECT_LOW_I)),
    .switch_on_i (HS_TURN_ON_I),
    .cmp_i       (HS_SHORT_CMP_I && CHARGER_OPTION_WORD_I[cfps_pkg::OPT_HS_EN_BIT]),
    .count_en_i  (count_en),
    .count_o     (),
    .limit_o     (hs_limit)
  );

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      latch_ff <= 1'b0;
    else if (UNDERVOLTAGE_LOCKOUT_I || ADAPTER_DETECT_LOW_I)
      latch_ff <= 1'b0;
    else if (ls_limit || hs_limit)
      latch_ff <= 1'b1;
  end

  // ==========================================================================
  // peak overcurrent: high side off for the rest of the cycle
  // ==========================================================================
  logic ocp_blank_ff;

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      ocp_blank_ff <= 1'b0;
    else if (CHARGE_PEAK_OVERCURRENT_I)
      ocp_blank_ff <= 1'b1;
    else if (CYCLE_START_I)
      ocp_blank_ff <= 1'b0;
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  logic low_any;
  logic conv_off;
  logic low_wait;
  logic ss_ff;

  assign low_any  = (low_st_ff != CFPS_LOW_IDLE);
  assign low_wait = (low_st_ff == CFPS_LOW_WAIT);
  assign conv_off = ovp_act || ovp_disable_ff || thermal_ff || latch_ff || low_wait;

  // soft-start requested on the exit from thermal shutdown or from the battery low restart wait
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      ss_ff <= 1'b0;
    else
      ss_ff <= (thermal_ff && !THERMAL_HOT_155_I && THERMAL_COOL_135_I) ||
               (low_wait && low_st_ff != CFPS_LOW_IDLE && CHARGE_ENABLE_OK_I &&
                low_tmr_ff == cfps_pkg::TMR_W'(cfps_pkg::LOW_RESTART_CYC - 1));
  end

  always_comb
  begin
    DRIVE_O                 = '0;
    DRIVE_O.hs_gate_en      = !conv_off && !ocp_blank_ff && !CHARGE_PEAK_OVERCURRENT_I;
    DRIVE_O.ls_gate_en      = !conv_off && !low_any;
    DRIVE_O.ls_refresh_only = low_any;
    DRIVE_O.current_cap     = low_any;
    DRIVE_O.discharge_sink  = ovp_act;
    DRIVE_O.soft_start      = ss_ff;
    DRIVE_O.charger_en      = !(ovp_disable_ff || latch_ff || thermal_ff || low_wait);
  end

  assign ADAPTER_PATH_SWITCH_ON_O         = !latch_ff;
  assign REVERSE_BLOCK_SWITCH_ON_O        = !latch_ff;
  assign BATTERY_PATH_SWITCH_ON_O         = latch_ff;
  assign GATE_DRIVE_REGULATOR_LIMIT_LOW_O = thermal_ff;
  assign LS_SHORT_THR_HIGH_O              = CHARGER_OPTION_WORD_I[cfps_pkg::OPT_LS_THR_BIT];
  assign HS_SHORT_DETECT_EN_O             = CHARGER_OPTION_WORD_I[cfps_pkg::OPT_HS_EN_BIT];
  assign LS_CYCLE_LIMIT_O                 = BOOST_ACTIVE_I && LS_SHORT_CMP_I;

  always_comb
  begin
    if (!CHARGER_OPTION_WORD_I[cfps_pkg::OPT_FADJ_EN_BIT])
      FREQ_TRIM_O = cfps_pkg::CFPS_FREQ_NOM;
    else if (CHARGER_OPTION_WORD_I[cfps_pkg::OPT_FADJ_UP_BIT])
      FREQ_TRIM_O = cfps_pkg::CFPS_FREQ_HIGH;
    else
      FREQ_TRIM_O = cfps_pkg::CFPS_FREQ_LOW;
  end

  assign STATUS_O = '{ovp: ovp_act, low: low_any, thermal: thermal_ff, latched: latch_ff};

  // ==========================================================================
  // checks
  // ==========================================================================
  a_ovp_gates_off : assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    ovp_act |-> (!DRIVE_O.hs_gate_en && !DRIVE_O.ls_gate_en))
    else $error("gates on during overvoltage");

  a_sink_follows : assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    DRIVE_O.discharge_sink == (BATTERY_OVER_104_I && !CHARGE_VOLTAGE_TARGET_ZERO_I))
    else $error("sink mismatch");

  a_zero_target : assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    CHARGE_VOLTAGE_TARGET_ZERO_I |-> !STATUS_O.ovp)
    else $error("overvoltage with zero target");

  a_ovp_disable : assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    $rose(ovp_disable_ff) |-> $past(ovp_tmr_ff) == cfps_pkg::TMR_W'(cfps_pkg::OVP_DISABLE_CYC))
    else $error("disable before interval");

  a_low_reset : assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    $rose(low_wait) |-> $past(low_tmr_ff) == cfps_pkg::TMR_W'(cfps_pkg::LOW_RESET_CYC - 1))
    else $error("battery low reset timing");

  a_thermal_hyst : assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    (thermal_ff && !THERMAL_COOL_135_I) |=> thermal_ff)
    else $error("thermal released early");

  a_reg_limit : assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    THERMAL_HOT_155_I |=> (GATE_DRIVE_REGULATOR_LIMIT_LOW_O && !DRIVE_O.charger_en))
    else $error("regulator limit mismatch");

  a_latch_paths : assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    latch_ff |-> (!ADAPTER_PATH_SWITCH_ON_O && !REVERSE_BLOCK_SWITCH_ON_O && BATTERY_PATH_SWITCH_ON_O))
    else $error("latch path switches wrong");

  a_latch_hold : assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    (latch_ff && !UNDERVOLTAGE_LOCKOUT_I && !ADAPTER_DETECT_LOW_I) |=> latch_ff)
    else $error("latch cleared without cause");

  a_ocp_cycle : assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    CHARGE_PEAK_OVERCURRENT_I |=> !DRIVE_O.hs_gate_en)
    else $error("high side on after peak overcurrent");

  a_freq_nominal : assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    !CHARGER_OPTION_WORD_I[cfps_pkg::OPT_FADJ_EN_BIT] |-> FREQ_TRIM_O == cfps_pkg::CFPS_FREQ_NOM)
    else $error("frequency trimmed while disabled");

endmodule // cfps_sequencer

/* cfps_fet_stage_model.sv */
// cfps_fet_stage_model: behavioural power stage feeding switching events and short comparator flags
// assumes the bench calls its tasks from one process and that the sequencer samples on rising edges
`timescale 1ns/1ps
module cfps_fet_stage_model
(
  // clock
  input  wire logic clk_i,
  // switching events and comparators
  output logic      cycle_start_o,
  output logic      hs_turn_on_o,
  output logic      ls_turn_on_o,
  output logic      hs_short_o,
  output logic      ls_short_o
);
  initial
  begin
    cycle_start_o = 1'b0;
    hs_turn_on_o  = 1'b0;
    ls_turn_on_o  = 1'b0;
    hs_short_o    = 1'b0;
    ls_short_o    = 1'b0;
  end

  // ==========================================================================
  // event sequencing
  // ==========================================================================
  task automatic step();
    @(posedge clk_i);
    #1;
  endtask

  // comparator flags held by the bench, e.g. a short during boost
  task automatic set_short(input logic hs, input logic ls);
    step();
    hs_short_o = hs;
    ls_short_o = ls;
  endtask

  // one switching period; dly below the blanking span lands inside it
  task automatic run_cycle(input logic hs_sh, input logic ls_sh, input int dly);
    step();
    cycle_start_o = 1'b1;
    step();
    cycle_start_o = 1'b0;
    hs_turn_on_o  = 1'b1;
    step();
    hs_turn_on_o  = 1'b0;
    repeat (dly) step();
    hs_short_o    = hs_sh;
    step();
    hs_short_o    = 1'b0;
    ls_turn_on_o  = 1'b1;
    step();
    ls_turn_on_o  = 1'b0;
    repeat (dly) step();
    ls_short_o    = ls_sh;
    step();
    ls_short_o    = 1'b0;
    repeat (4) step();
  endtask
endmodule // cfps_fet_stage_model

/* testbench.sv */
// testbench: self-checking bench for the charger fault protection sequencer
// assumes the power stage model drives switching events and short comparator flags and the bench drives every other flag
`timescale 1ns/1ps
module testbench;
  logic                 clk, rst_n, lockout, det_low, en_ok, tgt_zero;
  logic                 over, low, hot, cool, peak_oc, boost;
  logic [15:0]          opt;
  logic                 cyc_start, hs_on, ls_on, hs_sh, ls_sh;
  cfps_pkg::cfps_drive_t  drive;
  cfps_pkg::cfps_status_t status;
  cfps_pkg::cfps_freq_t   trim;
  logic                 ac_on, rb_on, bat_on, reg_low, ls_thr_hi, hs_det_en, ls_lim;
  int                   num_errors  = 0;
  int                   comparisons = 0;

  cfps_fet_stage_model i_fet
  (
    .clk_i(clk), .cycle_start_o(cyc_start), .hs_turn_on_o(hs_on), .ls_turn_on_o(ls_on),
    .hs_short_o(hs_sh), .ls_short_o(ls_sh)
  );

  cfps_sequencer i_dut
  (
    .CLK_SYS_I(clk), .RST_N_I(rst_n), .UNDERVOLTAGE_LOCKOUT_I(lockout), .ADAPTER_DETECT_LOW_I(det_low),
    .CHARGE_ENABLE_OK_I(en_ok), .CHARGER_OPTION_WORD_I(opt), .CHARGE_VOLTAGE_TARGET_ZERO_I(tgt_zero),
    .BATTERY_OVER_104_I(over), .BATTERY_LOW_I(low), .THERMAL_HOT_155_I(hot), .THERMAL_COOL_135_I(cool),
    .CHARGE_PEAK_OVERCURRENT_I(peak_oc), .LS_SHORT_CMP_I(ls_sh), .HS_SHORT_CMP_I(hs_sh),
    .BOOST_ACTIVE_I(boost), .CYCLE_START_I(cyc_start), .HS_TURN_ON_I(hs_on), .LS_TURN_ON_I(ls_on),
    .DRIVE_O(drive), .ADAPTER_PATH_SWITCH_ON_O(ac_on), .REVERSE_BLOCK_SWITCH_ON_O(rb_on),
    .BATTERY_PATH_SWITCH_ON_O(bat_on), .GATE_DRIVE_REGULATOR_LIMIT_LOW_O(reg_low), .FREQ_TRIM_O(trim),
    .LS_SHORT_THR_HIGH_O(ls_thr_hi), .HS_SHORT_DETECT_EN_O(hs_det_en), .LS_CYCLE_LIMIT_O(ls_lim),
    .STATUS_O(status)
  );

  // ==========================================================================
  // clock, reset, watchdog
  // ==========================================================================
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // the battery low reset alone needs about fifty thousand cycles
  initial
  begin
    repeat (60000) @(posedge clk);
    num_errors++;
    end_sim();
  end

  // ==========================================================================
  // helpers
  // ==========================================================================
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic test_done(input string name);
    $display("test %s done", name);
  endtask

  task automatic shorts(input int n, input logic hs, input logic ls, input int dly);
    repeat (n) i_fet.run_cycle(hs, ls, dly);
  endtask

  task automatic check_paths(input logic latched);
    check(ac_on, !latched, "adapter path");
    check(rb_on, !latched, "reverse block");
    check(bat_on, latched, "battery path");
    check(status.latched, latched, "latched status");
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================================
  // tests
  // ==========================================================================
  initial
  begin
    logic [1:0] exp_trim;
    {rst_n, lockout, det_low, tgt_zero, over, low, hot, peak_oc, boost} = '0;
    en_ok = 1'b1;
    cool  = 1'b1;
    opt   = 16'h0000;
    wait_cyc(3);
    rst_n = 1'b1;
    wait_cyc(2);
    check_paths(1'b0);
    test_done("reset");

    // option word as the host would write it
    for (int i = 0; i < 4; i++)
    begin
      opt = 16'h0000;
      {opt[10], opt[9]} = i[1:0];
      {opt[8], opt[7]}  = i[1:0];
      wait_cyc(1);
      exp_trim = !opt[9] ? 2'h0 : (opt[10] ? 2'h2 : 2'h1);
      check(trim, exp_trim, "frequency trim");
      check(ls_thr_hi, opt[7], "low side threshold");
      check(hs_det_en, opt[8], "high side detect");
    end
    opt = 16'h0000;
    test_done("options");

    over = 1'b1;
    wait_cyc(2);
    check(drive.hs_gate_en, 1'b0, "hs gate in ovp");
    check(drive.ls_gate_en, 1'b0, "ls gate in ovp");
    check(drive.discharge_sink, 1'b1, "sink in ovp");
    check(status.ovp, 1'b1, "ovp status");
    over = 1'b0;
    wait_cyc(2);
    check(drive.discharge_sink, 1'b0, "sink after ovp");
    check(drive.hs_gate_en, 1'b1, "hs gate after ovp");
    tgt_zero = 1'b1;
    over     = 1'b1;
    wait_cyc(2);
    check(status.ovp, 1'b0, "ovp with zero target");
    check(drive.discharge_sink, 1'b0, "sink zero target");
    {over, tgt_zero} = 2'b00;
    test_done("overvoltage");

    hot  = 1'b1;
    cool = 1'b0;
    wait_cyc(2);
    check(reg_low, 1'b1, "regulator limit hot");
    check(status.thermal, 1'b1, "thermal status");
    check(drive.hs_gate_en, 1'b0, "hs gate hot");
    check(drive.charger_en, 1'b0, "charger off hot");
    hot = 1'b0;
    wait_cyc(3);
    check(status.thermal, 1'b1, "thermal hysteresis");
    cool = 1'b1;
    wait_cyc(1);
    check(drive.soft_start, 1'b1, "soft-start on resume");
    wait_cyc(1);
    check(status.thermal, 1'b0, "thermal cleared");
    check(reg_low, 1'b0, "regulator limit cool");
    check(drive.soft_start, 1'b0, "soft-start one cycle");
    test_done("thermal");

    low = 1'b1;
    wait_cyc(3);
    check(status.low, 1'b1, "low status");
    check(drive.current_cap, 1'b1, "current cap");
    check(drive.ls_refresh_only, 1'b1, "refresh only");
    low = 1'b0;
    wait_cyc(3);
    check(drive.current_cap, 1'b0, "cap released");
    test_done("battery low");

    // battery held low until the charge cycle resets; a mid-run reset leaves the restart wait
    low = 1'b1;
    wait_cyc(cfps_pkg::LOW_RESET_CYC - 1);
    check(drive.charger_en, 1'b1, "charger before low reset");
    check(drive.ls_gate_en, 1'b0, "ls gate while low");
    wait_cyc(2);
    check(drive.charger_en, 1'b0, "charger after low reset");
    check(drive.hs_gate_en, 1'b0, "hs gate in low reset");
    low = 1'b0;
    wait_cyc(3);
    check(drive.charger_en, 1'b0, "no restart before interval");
    rst_n = 1'b0;
    wait_cyc(2);
    rst_n = 1'b1;
    wait_cyc(2);
    check(drive.charger_en, 1'b1, "charger after reset");
    check(status.low, 1'b0, "low status after reset");
    test_done("battery low reset");

    peak_oc = 1'b1;
    wait_cyc(1);
    peak_oc = 1'b0;
    wait_cyc(2);
    check(drive.hs_gate_en, 1'b0, "hs off rest of cycle");
    i_fet.run_cycle(1'b0, 1'b0, 12);
    check(drive.hs_gate_en, 1'b1, "hs back next cycle");
    test_done("peak overcurrent");

    // boost: the low side comparator only limits the cycle
    boost = 1'b1;
    i_fet.set_short(1'b0, 1'b1);
    wait_cyc(1);
    check(ls_lim, 1'b1, "cycle limit in boost");
    i_fet.set_short(1'b0, 1'b0);
    shorts(8, 1'b0, 1'b1, 12);
    check_paths(1'b0);
    boost = 1'b0;
    test_done("boost");

    shorts(8, 1'b0, 1'b1, 3);
    check_paths(1'b0);
    shorts(6, 1'b0, 1'b1, 12);
    check_paths(1'b0);
    shorts(1, 1'b0, 1'b1, 12);
    check_paths(1'b1);
    en_ok = 1'b0;
    wait_cyc(3);
    en_ok = 1'b1;
    wait_cyc(3);
    check_paths(1'b1);
    det_low = 1'b1;
    wait_cyc(2);
    det_low = 1'b0;
    wait_cyc(2);
    check_paths(1'b0);
    test_done("low side short");

    shorts(7, 1'b1, 1'b0, 12);
    check_paths(1'b0);
    opt[8] = 1'b1;
    shorts(7, 1'b1, 1'b0, 12);
    check_paths(1'b1);
    lockout = 1'b1;
    wait_cyc(2);
    lockout = 1'b0;
    wait_cyc(2);
    check_paths(1'b0);
    test_done("high side short");
    end_sim();
  end
endmodule // testbench
